// File: inc/hplr_map.vh
// Constants for the hold packet local responder
`ifndef HPLR_MAP_VH
`define HPLR_MAP_VH
`define HPLR_CLK_PERIOD_NS   100
`define HPLR_MS_TIME_NS      1000000
`define HPLR_MS_CYCLES       (`HPLR_MS_TIME_NS / `HPLR_CLK_PERIOD_NS)
`define HPLR_MS_PER_S        1000
`define HPLR_CNT_W           13
`define HPLR_CFG_MAX         13'h1FFE
`define HPLR_NET_PERIOD_DEF  13'h000A
`define HPLR_NET_TMO_DEF     13'h000A
`define HPLR_POLL_PER_DEF    13'h00C8
`define HPLR_REPLY_TMO_DEF   13'h01F4
`define HPLR_TERM_ADDR_DEF   8'h01
`define HPLR_ENABLE_DEF      1'b0
`endif

// File: core/hplr_tick.v
// Millisecond and second tick generator
`timescale 1ns/100ps
`default_nettype none
`include "hplr_map.vh"
module hplr_tick #(
    parameter integer MS_CYCLES = `HPLR_MS_CYCLES,
    parameter integer MS_PER_S  = `HPLR_MS_PER_S
) (
    input  wire clk_sys,
    input  wire rst,
    output reg  ms_tick_q,
    output reg  s_tick_q
);
    reg [23:0] cyc_q;
    reg [15:0] ms_q;

    // Divide the system clock into one-cycle tick pulses
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cyc_q     <= 24'h000000;
            ms_q      <= 16'h0000;
            ms_tick_q <= 1'b0;
            s_tick_q  <= 1'b0;
        end else begin
            ms_tick_q <= 1'b0;
            s_tick_q  <= 1'b0;
            if (cyc_q == MS_CYCLES[23:0] - 24'h000001) begin
                cyc_q     <= 24'h000000;
                ms_tick_q <= 1'b1;
                if (ms_q == MS_PER_S[15:0] - 16'h0001) begin
                    ms_q     <= 16'h0000;
                    s_tick_q <= 1'b1;
                end else begin
                    ms_q <= ms_q + 16'h0001;
                end
            end else begin
                cyc_q <= cyc_q + 24'h000001;
            end
        end
    end
endmodule // hplr_tick
`default_nettype wire

// File: core/hplr_top.v
// Hold packet local responder, master side and slave side
`timescale 1ns/100ps
`default_nettype none
`include "hplr_map.vh"
module hplr_top #(
    parameter integer SLV_W     = 2,
    parameter integer MS_CYCLES = `HPLR_MS_CYCLES,
    parameter integer MS_PER_S  = `HPLR_MS_PER_S
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire             role_master,
    input  wire             local_hold_emulation_enable,
    input  wire [12:0]      network_hold_period,
    input  wire [12:0]      network_hold_timeout,
    input  wire [12:0]      local_poll_period,
    input  wire [12:0]      local_reply_timeout,
    input  wire [7:0]       terminal_addr,
    input  wire             ser_hold_valid,
    input  wire [SLV_W-1:0] ser_hold_slave,
    output reg              ser_reply_valid_q,
    output reg  [SLV_W-1:0] ser_reply_slave_q,
    output reg              ser_fwd_valid_q,
    output reg  [SLV_W-1:0] ser_fwd_slave_q,
    output reg              net_hold_valid_q,
    output reg  [SLV_W-1:0] net_hold_slave_q,
    input  wire             net_reply_valid,
    input  wire [SLV_W-1:0] net_reply_slave,
    output wire [(1<<SLV_W)-1:0] slave_alive,
    output reg              poll_valid_q,
    output reg  [7:0]       poll_addr_q,
    input  wire             rtu_reply_valid,
    output reg              rtu_alive_q,
    input  wire             radio_hold_valid,
    output reg              radio_answer_valid_q,
    output reg              radio_fwd_valid_q
);
    localparam integer NUM = 1 << SLV_W;

    wire ms_tick;
    wire s_tick;
    wire emu_m = local_hold_emulation_enable & role_master;
    wire emu_s = local_hold_emulation_enable & ~role_master;

    // Limit a configured count to the legal range, zero counts as one
    function [12:0] clampf;
        input [12:0] v;
        begin
            if (v > `HPLR_CFG_MAX)
                clampf = `HPLR_CFG_MAX;
            else if (v == 13'h0000)
                clampf = 13'h0001;
            else
                clampf = v;
        end
    endfunction

    wire [12:0] net_per  = clampf(network_hold_period);
    wire [12:0] net_tmo  = clampf(network_hold_timeout);
    wire [12:0] poll_per = clampf(local_poll_period);
    wire [12:0] rep_tmo  = clampf(local_reply_timeout);

    // Shared timebase
    hplr_tick #(
        .MS_CYCLES (MS_CYCLES),
        .MS_PER_S  (MS_PER_S)
    ) u_tick (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ms_tick_q (ms_tick),
        .s_tick_q  (s_tick)
    );

    // ---------------- Master side ----------------
    wire [NUM-1:0]   pend_vec;
    wire [NUM-1:0]   alive_vec;
    reg  [SLV_W-1:0] grant;
    reg              send_now;
    integer          i;

    // Lowest pending slave wins the network slot
    always @* begin
        grant    = {SLV_W{1'b0}};
        send_now = 1'b0;
        for (i = NUM - 1; i >= 0; i = i - 1) begin
            if (pend_vec[i]) begin
                grant    = i[SLV_W-1:0];
                send_now = emu_m;
            end
        end
    end

    assign slave_alive = alive_vec;

    genvar g;
    generate
        for (g = 0; g < NUM; g = g + 1) begin : g_slv
            localparam integer     GI  = g;
            localparam [SLV_W-1:0] IDX = GI[SLV_W-1:0];
            reg  [12:0] per_q;
            reg  [12:0] tmo_q;
            reg         wait_q;
            reg         alive_q;
            reg         pend_q;
            wire        sent   = send_now && (grant == IDX);
            wire        got    = net_reply_valid && (net_reply_slave == IDX) && wait_q;
            wire        expire = wait_q && s_tick && (tmo_q + 13'h0001 >= net_tmo);

            assign pend_vec[g]  = pend_q;
            assign alive_vec[g] = alive_q;

            // Network period, timeout and liveness per slave
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    per_q   <= 13'h0000;
                    tmo_q   <= 13'h0000;
                    wait_q  <= 1'b0;
                    alive_q <= 1'b1;
                    pend_q  <= 1'b0;
                end else if (!emu_m) begin
                    per_q   <= 13'h0000;
                    tmo_q   <= 13'h0000;
                    wait_q  <= 1'b0;
                    alive_q <= 1'b1;
                    pend_q  <= 1'b0;
                end else begin
                    if (s_tick) begin
                        if (per_q + 13'h0001 >= net_per) begin
                            per_q  <= 13'h0000;
                            pend_q <= 1'b1;
                        end else begin
                            per_q <= per_q + 13'h0001;
                        end
                    end
                    if (sent) begin
                        pend_q <= 1'b0;
                        wait_q <= 1'b1;
                        tmo_q  <= 13'h0000;
                    end else if (got || expire) begin
                        wait_q <= 1'b0;
                    end else if (wait_q && s_tick) begin
                        tmo_q <= tmo_q + 13'h0001;
                    end
                    // Reply beats expiry, even when a new send starts
                    if (got) begin
                        alive_q <= 1'b1;
                    end else if (expire) begin
                        alive_q <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Serial hold handling and network send on the master side
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ser_reply_valid_q <= 1'b0;
            ser_reply_slave_q <= {SLV_W{1'b0}};
            ser_fwd_valid_q   <= 1'b0;
            ser_fwd_slave_q   <= {SLV_W{1'b0}};
            net_hold_valid_q  <= 1'b0;
            net_hold_slave_q  <= {SLV_W{1'b0}};
        end else begin
            ser_reply_valid_q <= 1'b0;
            ser_fwd_valid_q   <= 1'b0;
            net_hold_valid_q  <= send_now;
            if (send_now) begin
                net_hold_slave_q <= grant;
            end
            if (ser_hold_valid && role_master) begin
                if (!local_hold_emulation_enable) begin
                    ser_fwd_valid_q <= 1'b1; // Plain forwarding
                    ser_fwd_slave_q <= ser_hold_slave;
                end else if (alive_vec[ser_hold_slave]) begin
                    ser_reply_valid_q <= 1'b1;
                    ser_reply_slave_q <= ser_hold_slave;
                end
            end
        end
    end

    // ---------------- Slave side ----------------
    reg [12:0] poll_cnt_q;
    reg [12:0] rep_cnt_q;
    reg        rep_wait_q;
    wire       poll_fire = emu_s && ms_tick && (poll_cnt_q + 13'h0001 >= poll_per);
    wire       rep_got   = rtu_reply_valid && rep_wait_q;
    wire       rep_exp   = rep_wait_q && ms_tick && (rep_cnt_q + 13'h0001 >= rep_tmo);

    // Terminal polling, reply watch and radio hold answers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            poll_cnt_q           <= 13'h0000;
            rep_cnt_q            <= 13'h0000;
            rep_wait_q           <= 1'b0;
            rtu_alive_q          <= 1'b1;
            poll_valid_q         <= 1'b0;
            poll_addr_q          <= `HPLR_TERM_ADDR_DEF;
            radio_answer_valid_q <= 1'b0;
            radio_fwd_valid_q    <= 1'b0;
        end else begin
            poll_valid_q         <= 1'b0;
            radio_answer_valid_q <= 1'b0;
            radio_fwd_valid_q    <= 1'b0;
            if (!emu_s) begin
                poll_cnt_q  <= 13'h0000;
                rep_cnt_q   <= 13'h0000;
                rep_wait_q  <= 1'b0;
                rtu_alive_q <= 1'b1;
            end else begin
                if (poll_fire) begin
                    poll_cnt_q   <= 13'h0000;
                    poll_valid_q <= 1'b1;
                    poll_addr_q  <= terminal_addr;
                end else if (ms_tick) begin
                    poll_cnt_q <= poll_cnt_q + 13'h0001;
                end
                if (rep_got) begin
                    rtu_alive_q <= 1'b1;
                end else if (rep_exp) begin
                    rtu_alive_q <= 1'b0;
                end
                if (poll_fire) begin
                    rep_wait_q <= 1'b1;
                    rep_cnt_q  <= 13'h0000;
                end else if (rep_got || rep_exp) begin
                    rep_wait_q <= 1'b0;
                end else if (rep_wait_q && ms_tick) begin
                    rep_cnt_q <= rep_cnt_q + 13'h0001;
                end
            end
            // Radio holds on the slave side: forwarded with emulation off, answered while the terminal is alive
            if (radio_hold_valid && !role_master) begin
                if (!local_hold_emulation_enable) begin
                    radio_fwd_valid_q <= 1'b1;
                end else if (rtu_alive_q) begin
                    radio_answer_valid_q <= 1'b1;
                end
            end
        end
    end
endmodule // hplr_top
`default_nettype wire

// File: bench/hplr_top_chk.sv
// Assertion checker for the hold packet local responder
`timescale 1ns/100ps
`default_nettype none
module hplr_top_chk #(parameter integer SLV_W = 2) (
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic                  role_master,
    input wire logic                  local_hold_emulation_enable,
    input wire logic [7:0]            terminal_addr,
    input wire logic                  ser_hold_valid,
    input wire logic [SLV_W-1:0]      ser_hold_slave,
    input wire logic                  ser_reply_valid_q,
    input wire logic [SLV_W-1:0]      ser_reply_slave_q,
    input wire logic                  ser_fwd_valid_q,
    input wire logic                  net_hold_valid_q,
    input wire logic [(1<<SLV_W)-1:0] slave_alive,
    input wire logic                  poll_valid_q,
    input wire logic [7:0]            poll_addr_q,
    input wire logic                  rtu_alive_q,
    input wire logic                  radio_hold_valid,
    input wire logic                  radio_answer_valid_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire en = local_hold_emulation_enable;
    wire sh = ser_hold_valid & role_master;

    // Serial hold handling and network send on the master node
    a_alive_reply: assert property (sh & en & slave_alive[ser_hold_slave] |=>
        ser_reply_valid_q && ser_reply_slave_q == $past(ser_hold_slave)) else $error("no local reply");
    a_dead_silent: assert property (sh & en & !slave_alive[ser_hold_slave] |=> !ser_reply_valid_q)
        else $error("reply for dead slave");
    a_fwd_off: assert property (sh & !en |=> ser_fwd_valid_q & !ser_reply_valid_q)
        else $error("hold not forwarded");
    a_reply_cause: assert property (ser_reply_valid_q |-> $past(sh & en))
        else $error("reply without hold");
    a_net_only_on: assert property (net_hold_valid_q |-> $past(en & role_master))
        else $error("network hold while off");

    // Poll generation and radio answers on the slave node
    a_poll_addr: assert property (poll_valid_q |-> poll_addr_q == $past(terminal_addr)
        && $past(en & !role_master)) else $error("bad poll");
    a_poll_gap: assert property (poll_valid_q |=> !poll_valid_q [*3])
        else $error("polls too close");
    a_radio_cause: assert property (radio_answer_valid_q |-> $past(radio_hold_valid & rtu_alive_q & en))
        else $error("radio answer without cause");
    a_radio_dead: assert property (radio_hold_valid & !rtu_alive_q |=> !radio_answer_valid_q)
        else $error("radio answer while terminal dead");
endmodule // hplr_top_chk

bind hplr_top hplr_top_chk #(.SLV_W(SLV_W)) u_chk (.clk_sys, .rst, .role_master,
    .local_hold_emulation_enable, .terminal_addr, .ser_hold_valid, .ser_hold_slave,
    .ser_reply_valid_q, .ser_reply_slave_q, .ser_fwd_valid_q, .net_hold_valid_q, .slave_alive,
    .poll_valid_q, .poll_addr_q, .rtu_alive_q, .radio_hold_valid, .radio_answer_valid_q);
`default_nettype wire

// File: bench/hplr_rtu_model.sv
// Terminal model answering locally generated polls
`timescale 1ns/100ps
`default_nettype none
module hplr_rtu_model (
    input wire logic       clk_sys,
    input wire logic       poll_valid_q,
    input wire logic [7:0] poll_addr_q,
    input wire logic [7:0] own_addr,
    input wire logic       mute,
    input wire logic [3:0] dly,
    output logic           rtu_reply_valid
);
    // Reply to each poll for our address after dly cycles
    initial begin
        rtu_reply_valid = 1'b0;
        forever begin
            @(posedge clk_sys);
            #1;
            if (poll_valid_q && !mute && poll_addr_q == own_addr) begin
                repeat (dly) @(posedge clk_sys);
                #1 rtu_reply_valid = 1'b1;
                @(posedge clk_sys);
                #1 rtu_reply_valid = 1'b0;
            end
        end
    end
endmodule // hplr_rtu_model
`default_nettype wire

// File: bench/tb_hold_packet_local_responder.sv
// Self-checking bench for the hold packet local responder
`timescale 1ns/100ps
`default_nettype none
module tb_hold_packet_local_responder;
    logic        clk_sys, rst, role_master, en, ser_hold_valid, net_reply_valid, radio_hold_valid, mute;
    logic        ser_reply_valid_q, ser_fwd_valid_q, net_hold_valid_q, poll_valid_q, rtu_reply_valid;
    logic        rtu_alive_q, radio_answer_valid_q, radio_fwd_valid_q;
    logic [12:0] net_per, net_tmo, poll_per, reply_tmo;
    logic [7:0]  term_addr, poll_addr_q;
    logic [3:0]  dly, slave_alive;
    logic [1:0]  ser_hold_slave, net_reply_slave, ser_reply_slave_q, ser_fwd_slave_q, net_hold_slave_q;
    integer      mismatches, samples_checked, seed, t0, i, k, rtu_m;
    integer      alive_m[4];

    hplr_top #(.MS_CYCLES(4), .MS_PER_S(3)) u_hplr_top (.clk_sys, .rst, .role_master,
        .local_hold_emulation_enable(en), .network_hold_period(net_per), .network_hold_timeout(net_tmo),
        .local_poll_period(poll_per), .local_reply_timeout(reply_tmo), .terminal_addr(term_addr),
        .ser_hold_valid, .ser_hold_slave, .ser_reply_valid_q, .ser_reply_slave_q, .ser_fwd_valid_q,
        .ser_fwd_slave_q, .net_hold_valid_q, .net_hold_slave_q, .net_reply_valid, .net_reply_slave,
        .slave_alive, .poll_valid_q, .poll_addr_q, .rtu_reply_valid, .rtu_alive_q, .radio_hold_valid,
        .radio_answer_valid_q, .radio_fwd_valid_q);
    hplr_rtu_model u_hplr_rtu_model (.clk_sys, .poll_valid_q, .poll_addr_q, .own_addr(term_addr),
        .mute, .dly, .rtu_reply_valid);

    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end

    task chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    // Wait for a poll (1) or a network hold (0), bounded
    task wait_for(input int poll);
        for (k = 0; (poll ? poll_valid_q : net_hold_valid_q) !== 1'b1 && k < 200; k++) step;
        if (k == 200) chk("wait", 0, 1);
    endtask
    // Serial or radio hold pulse compared with the bench model
    task hold(input int radio, input logic [1:0] s);
        ser_hold_valid = !radio;
        radio_hold_valid = radio;
        ser_hold_slave = s;
        step;
        ser_hold_valid = 0;
        radio_hold_valid = 0;
        if (radio) begin
            chk("radio_answer", radio_answer_valid_q, en & rtu_m);
            chk("radio_fwd", radio_fwd_valid_q, !en);
        end else begin
            chk("ser_reply", ser_reply_valid_q, en & alive_m[s]);
            chk("ser_fwd", ser_fwd_valid_q, !en);
            if (!en || alive_m[s]) chk("slave_id", en ? ser_reply_slave_q : ser_fwd_slave_q, s);
        end
        step;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #(3000 * 100);
        mismatches++;
        finish_test;
    end

    // Main sequence: master side, then slave side
    initial begin
        seed = 32'h9314;
        {mismatches, samples_checked} = 0;
        {rst, role_master, en, ser_hold_valid, net_reply_valid, radio_hold_valid, mute} = 7'h60;
        {net_per, net_tmo, poll_per, reply_tmo} = {13'h4, 13'h1, 13'h6, 13'h2};
        {term_addr, dly, ser_hold_slave, net_reply_slave} = {8'h01, 4'h3, 2'h0, 2'h0};
        rtu_m = 1;
        alive_m = '{1, 1, 1, 1};
        repeat (5) @(posedge clk_sys);
        #1 rst = 0;
        chk("alive", {slave_alive, rtu_alive_q}, 5'h1F);
        chk("poll_addr", poll_addr_q, 8'h01);
        for (i = 0; i < 4; i++) hold(0, $random(seed));
        en = 1;
        hold(0, 2);
        wait_for(0);
        t0 = $time;
        for (i = 0; i < 4; i++) begin
            chk("net_slave", {net_hold_valid_q, net_hold_slave_q}, 4 + i);
            step;
        end
        net_reply_valid = 1;
        for (i = 0; i < 3; i++) begin
            net_reply_slave = i;
            step;
        end
        net_reply_valid = 0;
        repeat (16) step;
        alive_m[3] = 0;
        chk("slave_alive", slave_alive, 4'h7);
        hold(0, 3);
        hold(0, 1);
        wait_for(0);
        chk("net_period", ($time - t0) / 100, 48);
        repeat (3) step;
        net_reply_valid = 1;
        net_reply_slave = 3;
        step;
        net_reply_valid = 0;
        step;
        chk("revived", slave_alive[3], 1);
        role_master = 0;
        term_addr = $random(seed);
        wait_for(1);
        t0 = $time;
        chk("poll_addr", poll_addr_q, term_addr);
        step;
        wait_for(1);
        chk("poll_period", ($time - t0) / 100, 24);
        repeat (6) step;
        hold(1, 0);
        mute = 1;
        repeat (40) step;
        rtu_m = 0;
        chk("rtu_alive", rtu_alive_q, 0);
        hold(1, 0);
        en = 0;
        step;
        hold(1, 0);
        finish_test;
    end
endmodule // tb_hold_packet_local_responder
`default_nettype wire
